// File: pwm_action.sv
/*
  Applies one event action to a single PWM output level.
  Assumes events arrive as one-cycle pulses already filtered for priority.
*/
module pwm_action
  import pwm_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [EVT_N-1:0] events,
  input wire logic [EVT_N*ACT_W-1:0] actions,
  output logic level
);

  logic [ACT_W-1:0] act;

  // Events are mutually exclusive after filtering, so an OR of actions is safe
  always_comb begin
    act = ACT_NONE;
    for (int i = 0; i < EVT_N; i++) begin
      if (events[i]) begin
        act = act | actions[i*ACT_W +: ACT_W];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      level <= 1'b0;
    end else if (run) begin
      unique case (act)
        ACT_NONE: level <= level;
        ACT_TOGGLE: level <= ~level;
        ACT_LOW: level <= 1'b0;
        ACT_HIGH: level <= 1'b1;
      endcase
    end
  end

endmodule : pwm_action

// File: pwm_deadband.sv
/*
  Delays the rising edge of a signal by a programmable number of clocks.
  Assumes input comes from flip-flops on the same clock.
*/
module pwm_deadband
  import pwm_pkg::*;
#(
  parameter int WIDTH = DB_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic din,
  input wire logic [WIDTH-1:0] delay,
  output logic dout
);

  logic [WIDTH-1:0] cnt_ff;

  // Counts cycles din has been high; output rises when count reaches delay
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (!din) begin
      cnt_ff <= '0;
    end else if (cnt_ff < delay) begin
      cnt_ff <= cnt_ff + WIDTH'(1);
    end
  end

  // Zero delay passes the input straight through
  always_comb begin
    dout = din && (cnt_ff >= delay);
  end

endmodule : pwm_deadband

// File: pwm_generator_deadband.sv
/*
  One PWM generator: 16-bit timer, two comparators, event-driven signal
  generator and an optional dead-band stage.
  Assumes all settings come from logic on the same clock; outputs go to an
  output control stage that handles polarity and pin enables.
*/
// Function
// - One 16-bit timer counting down only or alternately up and down.
// - Down mode: load value to zero, reload, keep counting down.
// - Up/down mode: zero up to load, back down to zero, repeat.
// - Direction low in down mode, toggles at reversals in up/down mode.
// - One-cycle pulse at count zero and another at count equal to load.
// - In down mode the load pulse directly follows the zero pulse.
// - Each comparator pulses one cycle when count equals its match value.
// - Up/down matches qualified by direction into up and down events.
// - A match value above the load value never matches.
// - Down mode uses zero, load and both comparators' down matches.
// - Up/down mode uses zero, load and both up and down matches.
// - Matches coinciding with zero or load are ignored.
// - Simultaneous matches: first output uses first, second uses second.
// - Per event and output: no change, toggle, drive low or drive high.
// - Dead-band off: both generator outputs pass unchanged.
// - Dead-band on: second output dropped, both derived from the first.
// - First dead-band output delays each rising edge by a programmed amount.
// - Second dead-band output is inverted input with its own rising delay.
// - Pair active high, never both high, both low only in delays.
// - A downstream stage picks polarity and which signals reach pins.
// - New load and match values take effect when the timer reaches zero.
// - Interrupt on any selected raw event, unaffected by dead-band delays.
module pwm_generator_deadband
  import pwm_pkg::*;
#(
  parameter int WIDTH = CNT_W,
  parameter int DBW = DB_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic run,
  input wire logic updown_mode,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] first_match_value,
  input wire logic [WIDTH-1:0] second_match_value,
  input wire logic [EVT_N*ACT_W-1:0] first_actions,
  input wire logic [EVT_N*ACT_W-1:0] second_actions,
  input wire logic deadband_enable,
  input wire logic [DBW-1:0] rise_delay,
  input wire logic [DBW-1:0] fall_delay,
  input wire logic [EVT_N-1:0] irq_select,
  output logic first_pulse_output,
  output logic second_pulse_output,
  output logic irq,
  output logic [WIDTH-1:0] count_value,
  output logic direction,
  output logic zero_pulse,
  output logic load_pulse
);

  // ----------------------------------------------------------------------
  // Shadowed settings
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] load_ff;
  logic [WIDTH-1:0] match_a_ff;
  logic [WIDTH-1:0] match_b_ff;
  logic mode_ff;
  logic [WIDTH-1:0] cnt_ff;
  logic dir_ff;
  logic at_zero;

  always_comb begin
    at_zero = (cnt_ff == WIDTH'(CNT_ZERO));
  end

  // Settings only change at zero or while stopped so no pulse is cut short or stretched
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      load_ff <= '0;
      match_a_ff <= '0;
      match_b_ff <= '0;
      mode_ff <= MODE_DOWN;
    end else if (!run || at_zero) begin
      load_ff <= load_value;
      match_a_ff <= first_match_value;
      match_b_ff <= second_match_value;
      mode_ff <= updown_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      dir_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff <= '0;
      dir_ff <= 1'b0;
    end else if (mode_ff == MODE_DOWN) begin
      dir_ff <= 1'b0;
      if (at_zero) begin
        cnt_ff <= load_ff;
      end else begin
        cnt_ff <= cnt_ff - WIDTH'(CNT_ONE);
      end
    end else begin
      if (dir_ff) begin
        if (cnt_ff >= load_ff) begin
          dir_ff <= 1'b0;
          cnt_ff <= (load_ff == WIDTH'(CNT_ZERO)) ? cnt_ff : cnt_ff - WIDTH'(CNT_ONE);
        end else begin
          cnt_ff <= cnt_ff + WIDTH'(CNT_ONE);
        end
      end else begin
        if (at_zero) begin
          dir_ff <= 1'b1;
          cnt_ff <= (load_ff == WIDTH'(CNT_ZERO)) ? cnt_ff : cnt_ff + WIDTH'(CNT_ONE);
        end else begin
          cnt_ff <= cnt_ff - WIDTH'(CNT_ONE);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Comparators and events
  // ----------------------------------------------------------------------
  logic ev_zero;
  logic ev_load;
  logic match_a;
  logic match_b;
  logic up_now;
  logic [EVT_N-1:0] ev_a;
  logic [EVT_N-1:0] ev_b;
  logic [EVT_N-1:0] ev_all;

  always_comb begin
    ev_zero = run && at_zero;
    ev_load = run && (cnt_ff == load_ff);
    // Bound check excludes match values above load; a reload can set the count above the new load
    match_a = run && (cnt_ff == match_a_ff) && (match_a_ff <= load_ff);
    match_b = run && (cnt_ff == match_b_ff) && (match_b_ff <= load_ff);
    up_now = (mode_ff == MODE_UPDOWN) && dir_ff;
    ev_all = '0;
    ev_all[EV_ZERO] = ev_zero;
    ev_all[EV_LOAD] = ev_load;
    ev_all[EV_MA_UP] = match_a && up_now;
    ev_all[EV_MA_DN] = match_a && !up_now;
    ev_all[EV_MB_UP] = match_b && up_now;
    ev_all[EV_MB_DN] = match_b && !up_now;
    // Zero takes precedence over load when both hold at load of zero
    ev_a = '0;
    ev_a[EV_ZERO] = ev_zero;
    ev_a[EV_LOAD] = ev_load && !ev_zero;
    ev_b = ev_a;
    if (!ev_zero && !ev_load) begin
      ev_a[EV_MA_UP] = ev_all[EV_MA_UP];
      ev_a[EV_MA_DN] = ev_all[EV_MA_DN];
      ev_b[EV_MB_UP] = ev_all[EV_MB_UP];
      ev_b[EV_MB_DN] = ev_all[EV_MB_DN];
    end
  end

  // ----------------------------------------------------------------------
  // Signal generator
  // ----------------------------------------------------------------------
  logic gen_a;
  logic gen_b;

  pwm_action u_act_a (
    .clock(clock),
    .reset_n(reset_n),
    .run(run),
    .events(ev_a),
    .actions(first_actions),
    .level(gen_a)
  );

  pwm_action u_act_b (
    .clock(clock),
    .reset_n(reset_n),
    .run(run),
    .events(ev_b),
    .actions(second_actions),
    .level(gen_b)
  );

  // ----------------------------------------------------------------------
  // Dead-band
  // ----------------------------------------------------------------------
  logic db_hi;
  logic db_lo;

  pwm_deadband #(.WIDTH(DBW)) u_db_hi (
    .clock(clock),
    .reset_n(reset_n),
    .din(gen_a),
    .delay(rise_delay),
    .dout(db_hi)
  );

  pwm_deadband #(.WIDTH(DBW)) u_db_lo (
    .clock(clock),
    .reset_n(reset_n),
    .din(~gen_a),
    .delay(fall_delay),
    .dout(db_lo)
  );

  // Registered outputs; polarity and pin routing are left downstream
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_pulse_output <= 1'b0;
      second_pulse_output <= 1'b0;
    end else if (deadband_enable) begin
      first_pulse_output <= db_hi;
      second_pulse_output <= db_lo;
    end else begin
      first_pulse_output <= gen_a;
      second_pulse_output <= gen_b;
    end
  end

  // ----------------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      zero_pulse <= 1'b0;
      load_pulse <= 1'b0;
      count_value <= '0;
      direction <= 1'b0;
    end else begin
      irq <= |(ev_all & irq_select);
      zero_pulse <= ev_zero;
      load_pulse <= ev_load;
      count_value <= cnt_ff;
      direction <= dir_ff;
    end
  end

endmodule : pwm_generator_deadband

// File: pwm_generator_deadband_properties.sv
/*
  Port-level checks for the PWM generator.
  Assumes settings change only while the timer is stopped.
*/
module pwm_generator_deadband_properties
  import pwm_pkg::*;
#(
  parameter int WIDTH = CNT_W,
  parameter int DBW = DB_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic run,
  input wire logic updown_mode,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] first_match_value,
  input wire logic [WIDTH-1:0] second_match_value,
  input wire logic [EVT_N*ACT_W-1:0] first_actions,
  input wire logic [EVT_N*ACT_W-1:0] second_actions,
  input wire logic deadband_enable,
  input wire logic [DBW-1:0] rise_delay,
  input wire logic [DBW-1:0] fall_delay,
  input wire logic [EVT_N-1:0] irq_select,
  input wire logic first_pulse_output,
  input wire logic second_pulse_output,
  input wire logic irq,
  input wire logic [WIDTH-1:0] count_value,
  input wire logic direction,
  input wire logic zero_pulse,
  input wire logic load_pulse
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence stopped_two;
    !run ##1 !run;
  endsequence
  sequence down_zero;
    $past(run) && !updown_mode && zero_pulse;
  endsequence
  sequence db_steady;
    deadband_enable [*3];
  endsequence
  AST_STOPPED_IDLE: assert property (stopped_two |=> count_value == 0 && !direction)
    else $error("timer not idle while stopped");
  AST_RESET_LOW: assert property (!$past(reset_n) |-> !first_pulse_output && !second_pulse_output)
    else $error("outputs not low after reset");
  AST_DOWN_STEP: assert property ($past(run) && !updown_mode && count_value != 0 |=> count_value == $past(count_value) - 1)
    else $error("down count did not decrement");
  AST_DOWN_RELOAD: assert property (down_zero |=> load_pulse)
    else $error("load pulse not right after zero");
  AST_DOWN_DIR: assert property (!updown_mode |-> !direction)
    else $error("direction high in down mode");
  AST_PEAK_FALL: assert property (load_pulse && updown_mode |=> !direction)
    else $error("direction not low at peak");
  AST_TROUGH_RISE: assert property (zero_pulse && updown_mode && $past(run, 2) |=> direction)
    else $error("direction not high at trough");
  AST_DB_EXCL: assert property (db_steady |-> !(first_pulse_output && second_pulse_output))
    else $error("dead-band pair both high");
  AST_IRQ_ZERO: assert property ($past(run) && zero_pulse && irq_select[0] && $past(irq_select[0]) |-> irq)
    else $error("selected zero event gave no interrupt");
  AST_IRQ_MASK: assert property (~|irq_select && ~|$past(irq_select) |-> !irq)
    else $error("interrupt with no event selected");
endmodule : pwm_generator_deadband_properties

// File: pwm_generator_deadband_tb.sv
/*
  Self-checking bench: high times and periods per timer cycle.
  Assumes the design, its package and the output stage model.
*/
module pwm_generator_deadband_tb;
  import pwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int p; int a; int b;} rec_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic updown_mode = 1'b0;
  logic deadband_enable = 1'b0;
  logic [15:0] load_value = 16'h0000;
  logic [15:0] first_match_value = 16'h0000;
  logic [15:0] second_match_value = 16'h0000;
  logic [11:0] first_actions = 12'h000;
  logic [11:0] second_actions = 12'h000;
  logic [7:0] rise_delay = 8'h00;
  logic [7:0] fall_delay = 8'h00;
  logic [5:0] irq_select = 6'h00;
  logic first_pulse_output, second_pulse_output, irq, direction, zero_pulse, load_pulse;
  logic [15:0] count_value;
  logic [1:0] pins;
  logic [31:0] seed = 32'h00000027;
  rec_t exp_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int skip = 0;
  int cyc, ca, cb;
  initial begin
    forever #50 clock = ~clock;
  end
  pwm_generator_deadband u_dut (
    .clock(clock),
    .reset_n(reset_n),
    .run(run),
    .updown_mode(updown_mode),
    .load_value(load_value),
    .first_match_value(first_match_value),
    .second_match_value(second_match_value),
    .first_actions(first_actions),
    .second_actions(second_actions),
    .deadband_enable(deadband_enable),
    .rise_delay(rise_delay),
    .fall_delay(fall_delay),
    .irq_select(irq_select),
    .first_pulse_output(first_pulse_output),
    .second_pulse_output(second_pulse_output),
    .irq(irq),
    .count_value(count_value),
    .direction(direction),
    .zero_pulse(zero_pulse),
    .load_pulse(load_pulse)
  );
  pwm_output_stage u_out (.pulse_in({second_pulse_output, first_pulse_output}), .invert(2'h0),
    .pin_enable(2'h3), .pin_out(pins));
  function automatic int rnd(input int lo, input int hi);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return lo + int'(seed % (hi - lo + 1));
  endfunction : rnd
  function automatic logic [11:0] act(input int ev, input logic [1:0] code);
    return 12'(code) << (2 * ev);
  endfunction : act
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check_rec(input rec_t e, input int p, input int a, input int b);
    tests_run++;
    if (e.p != p || e.a != a || e.b != b) begin
      miscompares++;
      $display("CHECK FAILED %0t: p %0d/%0d a %0d/%0d b %0d/%0d", $time, p, e.p, a, e.a, b, e.b);
    end
  endtask : check_rec
  // Period monitor: skips the first two intervals after a start
  always @(negedge clock) begin
    if (run !== 1'b1) begin
      skip = 0;
    end else if (zero_pulse === 1'b1) begin
      if (skip >= 2 && exp_q.size() > 0) begin
        check_rec(exp_q.pop_front(), cyc, ca, cb);
      end
      skip++;
      cyc = 0;
      ca = 0;
      cb = 0;
    end
    cyc++;
    ca += (pins[0] === 1'b1) ? 1 : 0;
    cb += (pins[1] === 1'b1) ? 1 : 0;
  end
  task automatic run_test(input logic ud, input logic db, input int l, input int a, input int b);
    int r, f, ha, hb, per;
    r = rnd(0, 7);
    f = rnd(0, 7);
    per = ud ? 2 * l : l + 1;
    if (ud) begin
      ha = (a > 0 && a < l) ? 2 * (l - a) : 0;
      hb = (b > 0 && b < l) ? 2 * (l - b) : 0;
    end else begin
      ha = (a > 0 && a < l) ? 1 + l - a : l + 1;
      hb = (b > 0 && b < l) ? b + 1 : 0;
    end
    if (db) begin
      hb = per - ha - f;
      ha = ha - r;
    end
    @(posedge clock);
    updown_mode <= ud;
    deadband_enable <= db;
    load_value <= 16'(l);
    first_match_value <= 16'(a);
    second_match_value <= 16'(b);
    rise_delay <= 8'(r);
    fall_delay <= 8'(f);
    irq_select <= ud ? 6'(rnd(0, 63)) | 6'h01 : 6'h00;
    first_actions <= ud ? act(EV_ZERO, ACT_LOW) | act(EV_MA_UP, ACT_TOGGLE) | act(EV_MA_DN, ACT_TOGGLE)
      : act(EV_ZERO, ACT_HIGH) | act(EV_MA_DN, ACT_LOW);
    second_actions <= ud ? act(EV_ZERO, ACT_LOW) | act(EV_MB_UP, ACT_HIGH) | act(EV_MB_DN, ACT_LOW)
      : act(EV_LOAD, ACT_LOW) | act(EV_MB_DN, ACT_HIGH);
    repeat (4) @(posedge clock);
    repeat (3) exp_q.push_back('{per, ha, hb});
    run <= 1'b1;
    for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(posedge clock);
    if (exp_q.size() > 0) begin
      miscompares++;
      $display("CHECK FAILED %0t: no result", $time);
      give_verdict();
    end
    run <= 1'b0;
    repeat (3) @(posedge clock);
    $display("Test done: mode %0d deadband %0d load %0d", ud, db, l);
  endtask : run_test
  initial begin
    int l;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    run_test(1'b0, 1'b0, 40, 13, 13);
    run_test(1'b0, 1'b0, 30, 35, 30);
    run_test(1'b0, 1'b0, 25, 0, 1);
    run_test(1'b1, 1'b0, 20, 22, 20);
    for (int i = 0; i < 3; i++) begin
      l = rnd(30, 60);
      run_test(1'b1, 1'b0, l, rnd(1, l - 1), rnd(1, l - 1));
      run_test(1'b0, 1'b1, l, rnd(10, l - 10), rnd(0, l + 5));
      run_test(1'b1, 1'b1, l, rnd(10, l - 10), 0);
    end
    give_verdict();
  end
endmodule : pwm_generator_deadband_tb
bind pwm_generator_deadband pwm_generator_deadband_properties #(.WIDTH(WIDTH), .DBW(DBW)) u_props (
  .clock(clock),
  .reset_n(reset_n),
  .run(run),
  .updown_mode(updown_mode),
  .load_value(load_value),
  .first_match_value(first_match_value),
  .second_match_value(second_match_value),
  .first_actions(first_actions),
  .second_actions(second_actions),
  .deadband_enable(deadband_enable),
  .rise_delay(rise_delay),
  .fall_delay(fall_delay),
  .irq_select(irq_select),
  .first_pulse_output(first_pulse_output),
  .second_pulse_output(second_pulse_output),
  .irq(irq),
  .count_value(count_value),
  .direction(direction),
  .zero_pulse(zero_pulse),
  .load_pulse(load_pulse)
);

// File: pwm_output_stage.sv
/*
  Model of the output control stage after the generator.
  Assumes registered levels from the generator clock domain.
*/
module pwm_output_stage (
  input wire logic [1:0] pulse_in,
  input wire logic [1:0] invert,
  input wire logic [1:0] pin_enable,
  output logic [1:0] pin_out
);
  assign pin_out = (pulse_in ^ invert) & pin_enable;
endmodule : pwm_output_stage

// File: pwm_pkg.sv
/*
  Shared constants and types for the PWM generator unit.
  Assumes a single PWM clock; no register bus, all settings arrive as ports.
*/
package pwm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int DB_W = 8;
  localparam int ACT_W = 2;
  localparam int EVT_N = 6;

  // ----------------------------------------------------------------------
  // Event action codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;

  // ----------------------------------------------------------------------
  // Event index into a packed action vector
  // ----------------------------------------------------------------------
  localparam int EV_ZERO = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_MA_UP = 2;
  localparam int EV_MA_DN = 3;
  localparam int EV_MB_UP = 4;
  localparam int EV_MB_DN = 5;

  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] DB_ZERO = 8'h00;
  localparam logic [7:0] DB_ONE = 8'h01;

  typedef enum logic {
    MODE_DOWN,
    MODE_UPDOWN
  } count_mode_t;

endpackage : pwm_pkg
